/* File: rtl/swr_supervisor.sv */
// Supervisor: watchdog, power-on reset, power fail and RAM write protect
// ------------------------------------------------------------------
// What this block does
// - A missed timeout makes the block issue a reset pulse to the host.
// - A floating kick input disables the watchdog, its resets and its flag.
// - The power fail warning is low while the sensed input is below 1.3 V.
// - Reset is held low while the supply is below the reset threshold.
// - After supply recovery reset stays low 50 ms (200 ms variant).
// - Tick periods come from the timing source input when timing_source_select is low.
// - A second reset output is active high, the inverse of the first.
// - With supply good the RAM chip select passes through one clock later.
// - With supply low the RAM chip select is forced high.
// - Default timing gives a 50 ms reset pulse 1.6 s after the last kick.
// - Reset pulses repeat every 1.6 s until a new kick is seen.
// - The expired flag goes low on timeout and stays low until a kick edge.
// - Battery drive is low while supply is above battery, high otherwise.
// ------------------------------------------------------------------
`timescale 1ns/10ps
`default_nettype none
module swr_supervisor
  import swr_pkg::*;
#(
  parameter int unsigned WD_CYC = WD_TIMEOUT_CYC,
  parameter int unsigned RST_CYC = RST_WIDTH_CYC,
  parameter int unsigned RST_LONG_CYC = RST_WIDTH_LONG_CYC,
  parameter bit LONG_RESET = 1'b0
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic watchdog_kick_in,
  input wire logic watchdog_kick_float,
  input wire swr_sense_s sense_raw,
  input wire logic timing_source_select,
  input wire logic timing_source_input,
  input wire logic ram_sel_in_n,
  output logic reset_out_n,
  output logic reset_out,
  output logic watchdog_expired_n,
  output logic power_fail_warn_n,
  output logic backup_active_drive,
  output logic ram_sel_out_n
);

  // ----------------------------------------------------------------
  // Input synchronisers and edge detection
  // ----------------------------------------------------------------
  swr_sense_s sense_meta;
  swr_sense_s sense;
  logic kick_q;
  logic src_q;
  logic kick_edge;
  logic tick;
  logic wd_on;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sense_meta <= SENSE_RST;
      sense <= SENSE_RST;
    end else begin
      sense_meta <= sense_raw;
      sense <= sense_meta;
    end
  end

  // Previous levels of kick and timing source, for edge detection
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      kick_q <= 1'b0;
      src_q <= 1'b0;
    end else begin
      kick_q <= watchdog_kick_in;
      src_q <= timing_source_input;
    end
  end

  // both edges count as a kick
  assign kick_edge = (watchdog_kick_in ^ kick_q) & ~watchdog_kick_float;
  // floating kick input disables the watchdog
  assign wd_on = ~watchdog_kick_float;
  // rising edges of the timing source replace the system clock tick
  assign tick = timing_source_select | (timing_source_input & ~src_q);

  // Limits follow the selected timing source
  function automatic logic [CNT_W-1:0] limit(input logic internal,
                                             input int unsigned int_cyc,
                                             input int unsigned alt_tk);
    limit = internal ? int_cyc[CNT_W-1:0] : alt_tk[CNT_W-1:0];
  endfunction

  logic [CNT_W-1:0] wd_limit;
  logic [CNT_W-1:0] rst_limit;
  assign wd_limit = limit(timing_source_select, WD_CYC, ALT_WD_TICKS);
  // variant selects the long reset width under internal timing only; alternate timing always uses ALT_RST_TICKS
  assign rst_limit = limit(timing_source_select,
                           LONG_RESET ? RST_LONG_CYC : RST_CYC,
                           ALT_RST_TICKS);

  // ----------------------------------------------------------------
  // Watchdog timeout counter
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] wd_cnt;
  logic wd_fire;

  // fire after a full timeout with no kick; count wraps to repeat
  assign wd_fire = wd_on & ~kick_edge & tick & ~sense.supply_low &
                   (wd_cnt >= wd_limit - CNT_ONE);

  // a kick restarts the count; supply low holds it at zero
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wd_cnt <= CNT_ZERO;
    end else if (!wd_on || kick_edge || sense.supply_low || wd_fire) begin
      wd_cnt <= CNT_ZERO;
    end else if (tick) begin
      wd_cnt <= wd_cnt + CNT_ONE;
    end
  end

  // expired flag low on timeout until the next kick edge
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      watchdog_expired_n <= 1'b1;
    end else if (!wd_on || kick_edge) begin
      watchdog_expired_n <= 1'b1;
    end else if (wd_fire) begin
      watchdog_expired_n <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Reset sequencer
  // ----------------------------------------------------------------
  swr_phase_e phase;
  logic [CNT_W-1:0] rst_cnt;

  // held while supply low; timed stretch afterwards
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      phase <= SWR_LOW;
      rst_cnt <= CNT_ZERO;
    end else begin
      case (phase)
        SWR_LOW: begin
          rst_cnt <= CNT_ZERO;
          if (!sense.supply_low) begin
            phase <= SWR_STRETCH;
          end
        end
        SWR_STRETCH: begin
          if (sense.supply_low) begin
            phase <= SWR_LOW;
            rst_cnt <= CNT_ZERO;
          end else if (wd_fire) begin // fresh timeout, full width again
            rst_cnt <= CNT_ZERO;
          end else if (tick) begin
            if (rst_cnt >= rst_limit - CNT_ONE) begin
              phase <= SWR_RUN;
              rst_cnt <= CNT_ZERO;
            end else begin
              rst_cnt <= rst_cnt + CNT_ONE;
            end
          end
        end
        SWR_RUN: begin
          rst_cnt <= CNT_ZERO;
          if (sense.supply_low) begin
            phase <= SWR_LOW;
          end else if (wd_fire) begin
            phase <= SWR_STRETCH;
          end
        end
        default: begin
          phase <= SWR_LOW;
          rst_cnt <= CNT_ZERO;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  logic next_reset_n;
  assign next_reset_n = (phase == SWR_RUN) & ~sense.supply_low & ~wd_fire;

  // both reset polarities from one source, never apart
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      reset_out_n <= 1'b0;
      reset_out <= 1'b1;
    end else begin
      reset_out_n <= next_reset_n;
      reset_out <= ~next_reset_n;
    end
  end

  // warning follows the comparator; battery drive
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      power_fail_warn_n <= 1'b0;
      backup_active_drive <= 1'b1;
    end else begin
      power_fail_warn_n <= ~sense.pf_below;
      backup_active_drive <= sense.batt_supplying;
    end
  end

  // chip select gated by supply; costs one cycle of latency
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ram_sel_out_n <= 1'b1;
    end else begin
      ram_sel_out_n <= ram_sel_in_n | sense.supply_low;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence kick_seen;
    kick_edge;
  endsequence

  sequence fire_seen;
    wd_fire;
  endsequence

  reset_polarity_a: assert property (
    @(posedge sys_clk) disable iff (!rst_b) reset_out == ~reset_out_n)
    else $error("reset outputs not inverse");

  supply_hold_a: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    sense.supply_low |=> !reset_out_n)
    else $error("reset released while supply low");

  ram_block_a: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    sense.supply_low |=> ram_sel_out_n)
    else $error("chip select active while supply low");

  ram_pass_a: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    !sense.supply_low |=> ram_sel_out_n == $past(ram_sel_in_n))
    else $error("chip select not passed through");

  warn_follow_a: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    ##1 power_fail_warn_n == !$past(sense.pf_below))
    else $error("power fail warning wrong");

  batt_drive_a: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    ##1 backup_active_drive == $past(sense.batt_supplying))
    else $error("battery drive wrong");

  fire_reset_a: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    fire_seen |=> !reset_out_n ##1 !reset_out_n)
    else $error("no reset pulse after timeout");

  expired_set_a: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    fire_seen |=> !watchdog_expired_n)
    else $error("expired flag not set");

  expired_clear_a: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    kick_seen |=> watchdog_expired_n && wd_cnt == CNT_ZERO)
    else $error("kick did not clear flag or count");

  float_quiet_a: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    watchdog_kick_float |-> !wd_fire ##1 watchdog_expired_n)
    else $error("watchdog active while floating");

endmodule
`default_nettype wire

/* File: rtl/swr_pkg.sv */
// Shared constants and types for the supervisor watchdog reset block
package swr_pkg;

  // ----------------------------------------------------------------
  // Clock and timing figures
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned WD_TIMEOUT_MS = 1600;
  localparam int unsigned RST_WIDTH_MS = 50;
  localparam int unsigned RST_WIDTH_LONG_MS = 200;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
  localparam int unsigned WD_TIMEOUT_CYC = WD_TIMEOUT_MS * CYC_PER_MS;
  localparam int unsigned RST_WIDTH_CYC = RST_WIDTH_MS * CYC_PER_MS;
  localparam int unsigned RST_WIDTH_LONG_CYC = RST_WIDTH_LONG_MS * CYC_PER_MS;
  // Alternate timing source periods, counted in external ticks
  localparam int unsigned ALT_WD_TICKS = 1000;
  localparam int unsigned ALT_RST_TICKS = 100;

  // ----------------------------------------------------------------
  // Counter width and reset values
  // ----------------------------------------------------------------
  localparam int unsigned CNT_W = 32;
  localparam logic [CNT_W-1:0] CNT_ZERO = 32'h0000_0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 32'h0000_0001;

  // Comparator results from the analog front end
  typedef struct packed {
    logic supply_low;
    logic pf_below;
    logic batt_supplying;
  } swr_sense_s;

  localparam swr_sense_s SENSE_RST = '{supply_low: 1'b1, pf_below: 1'b1,
                                       batt_supplying: 1'b1};

  typedef enum logic [1:0] {
    SWR_LOW,
    SWR_STRETCH,
    SWR_RUN
  } swr_phase_e;

endpackage

/* File: testbench/swr_host_model.sv */
// Host processor model that services the watchdog kick line
`timescale 1ns/10ps
`default_nettype none
module swr_host_model (
  input wire logic sys_clk,
  input wire logic kick_en,
  input wire logic kick_float,
  output logic watchdog_kick_in
);
  int cnt = 0;

  initial watchdog_kick_in = 1'b0;

  // ----------------------------------------------------------------
  // Kick cadence
  // ----------------------------------------------------------------
  // kick or float
  // Toggle every 16 cycles, well inside the timeout; a released pin
  // wanders every cycle so a lazy design cannot read it as quiet
  always @(negedge sys_clk) begin
    cnt = (cnt + 1) % 16;
    if (kick_float) begin
      watchdog_kick_in <= ~watchdog_kick_in;
    end else if (kick_en && cnt == 0) begin
      watchdog_kick_in <= ~watchdog_kick_in;
    end
  end
endmodule
`default_nettype wire

/* File: testbench/test_supervisor_watchdog_reset.sv */
// Self-checking testbench for the supervisor watchdog reset block
`timescale 1ns/10ps
`default_nettype none
module test_supervisor_watchdog_reset
  import swr_pkg::*;
;
  localparam int WD = 40;
  localparam int RW = 8;
  logic sys_clk, rst_b, kick_en, kick_float, kick, ram_in_n, pf, bt, ri;
  logic rst_n, rst_hi, exp_n, pfw_n, batt_drv, ram_out_n;
  logic kprev = 1'b0;
  logic rprev = 1'b0;
  logic tsel;
  logic tsrc = 1'b0;
  swr_sense_s sense;
  int bad_count = 0, compares = 0, since = 0, lowlen = 0, gap = 0, n;
  int q_since[$], q_gap[$], q_low[$];

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  swr_supervisor #(.WD_CYC(WD), .RST_CYC(RW), .RST_LONG_CYC(16),
    .LONG_RESET(1'b0)) i_swr_supervisor (.sys_clk(sys_clk),
    .rst_b(rst_b), .watchdog_kick_in(kick),
    .watchdog_kick_float(kick_float), .sense_raw(sense),
    .timing_source_select(tsel), .timing_source_input(tsrc),
    .ram_sel_in_n(ram_in_n), .reset_out_n(rst_n), .reset_out(rst_hi),
    .watchdog_expired_n(exp_n), .power_fail_warn_n(pfw_n),
    .backup_active_drive(batt_drv), .ram_sel_out_n(ram_out_n));

  // Free-running timing source; must be ignored while internal timing runs
  always @(negedge sys_clk) tsrc <= ~tsrc;

  swr_host_model i_swr_host_model (.sys_clk(sys_clk), .kick_en(kick_en),
    .kick_float(kick_float), .watchdog_kick_in(kick));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic in_rng(input int v, input int lo, input int hi);
    check(32'(v >= lo && v <= hi), 32'h0000_0001);
  endtask

  task automatic print_verdict();
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Reference model: kick age, pulse widths and pulse spacing
  // ----------------------------------------------------------------
  // Sampled 1 ns after the edge so registered outputs have landed
  always @(posedge sys_clk) begin
    #1;
    if (rst_b) check({31'h0000_0000, rst_hi ^ rst_n}, 32'h0000_0001);
    since = (kick !== kprev) ? 0 : since + 1;
    kprev = kick;
    if (rst_n === 1'b0 && rprev === 1'b1) begin
      q_since.push_back(since);
      q_gap.push_back(gap);
      gap = 0;
    end
    if (rst_n === 1'b1 && rprev === 1'b0) q_low.push_back(lowlen);
    lowlen = (rst_n === 1'b0 && rst_b) ? lowlen + 1 : 0;
    gap++;
    rprev = rst_n;
  end

  // Hang guard, about twice the roughly five thousand cycles of the tests
  initial begin
    #250_000;
    bad_count++;
    print_verdict();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    kick_en = 1'b0;
    kick_float = 1'b0;
    tsel = 1'b1;
    ram_in_n = 1'b1;
    sense = '{supply_low: 1'b0, pf_below: 1'b0, batt_supplying: 1'b0};
    rst_b = 1'b0;
    n = $urandom(32'h0c0c_05c1);
    repeat (6) @(negedge sys_clk);
    rst_b = 1'b1;
    kick_en = 1'b1;
    repeat (RW + 12) @(negedge sys_clk);
    check(q_low.size(), 1);
    in_rng(q_low[0], RW, RW + 6);
    q_low.delete();
    repeat (5 * WD) @(negedge sys_clk);
    check(q_since.size(), 0);
    check(32'(exp_n), 32'h0000_0001);
    // Starved watchdog: expect exactly three pulses
    kick_en = 1'b0;
    repeat (3 * WD + 10) @(negedge sys_clk);
    check(q_since.size(), 3);
    check(32'(exp_n), 32'h0000_0000);
    in_rng(q_since[0], WD, WD + 6);
    in_rng(q_gap[1], WD - 2, WD + 2);
    in_rng(q_low[0], RW, RW + 3);
    kick_en = 1'b1;
    repeat (24) @(negedge sys_clk);
    check(32'(exp_n), 32'h0000_0001);
    q_since.delete();
    // Released pin: no pulse and no flag however long
    kick_float = 1'b1;
    repeat (3 * WD) @(negedge sys_clk);
    check(q_since.size(), 0);
    check(32'(exp_n), 32'h0000_0001);
    kick_float = 1'b0;
    repeat (8) begin
      pf = 1'($urandom);
      bt = 1'($urandom);
      ri = 1'($urandom);
      sense.pf_below = pf;
      sense.batt_supplying = bt;
      ram_in_n = ri;
      repeat (4) @(negedge sys_clk);
      check(32'(pfw_n), 32'(!pf));
      check(32'(batt_drv), 32'(bt));
      check(32'(ram_out_n), 32'(ri));
      sense.supply_low = 1'b1;
      repeat (4) @(negedge sys_clk);
      check(32'(ram_out_n), 32'h0000_0001);
      check(32'(rst_n), 32'h0000_0000);
      sense.supply_low = 1'b0;
      q_low.delete();
      repeat (RW + 8) @(negedge sys_clk);
      in_rng(q_low[0], RW, RW + 8);
    end
    // Alternate timing: one tick every second cycle stretches both periods
    tsel = 1'b0;
    repeat (20) @(negedge sys_clk);
    kick_en = 1'b0;
    q_since.delete();
    q_gap.delete();
    q_low.delete();
    repeat (4 * ALT_WD_TICKS + 300) @(negedge sys_clk);
    check(q_since.size(), 2);
    in_rng(q_since[0], 2 * ALT_WD_TICKS - 1, 2 * ALT_WD_TICKS + 2);
    in_rng(q_gap[1], 2 * ALT_WD_TICKS - 2, 2 * ALT_WD_TICKS + 2);
    in_rng(q_low[0], 2 * ALT_RST_TICKS - 1, 2 * ALT_RST_TICKS + 2);
    check(32'(exp_n), 32'h0000_0000);
    print_verdict();
  end
endmodule
`default_nettype wire
